// [imx_defs.vh]
// constants for the indirect move and miscellaneous op execution block
// assumes a decoder that presents one decoded op per issue pulse
// Summary of operation
// - window register accesses go through pointer address
// - pointer is 16 bits and wraps both ways
// - pointer auto update leaves status flags alone
// - software reset resets device, clears flag
// - return pops stack into program counter
// - return sets irq enable, two cycles
// - xor literal into working register, zero flag
// - xor file register, destination bit selects target
// - indirect move modes and signed offset form
`ifndef IMX_DEFS_VH
`define IMX_DEFS_VH
// ****************************************************************
// op codes presented by the decoder
// ****************************************************************
`define IMX_OP_IDLE 3'h0
`define IMX_OP_MOVE_W_INDIRECT_OP 3'h1
`define IMX_OP_MOVE_W_INDIRECT_OP_K 3'h2
`define IMX_OP_RESET 3'h3
`define IMX_OP_RETIRQ 3'h4
`define IMX_OP_XOR_LITERAL_OP 3'h5
`define IMX_OP_XOR_FILE_OP 3'h6
// ****************************************************************
// indirect move mode field
// ****************************************************************
`define IMX_MM_PREINC 2'h0
`define IMX_MM_PREDEC 2'h1
`define IMX_MM_POSTINC 2'h2
`define IMX_MM_POSTDEC 2'h3
// ****************************************************************
// fields, reset values and timing
// ****************************************************************
`define IMX_GIE_BIT 7
`define IMX_RI_RESET 1'h1
`define IMX_PTR_RESET 16'h0000
`define IMX_W_RESET 8'h00
`define IMX_ZERO_RESET 1'h0
`define IMX_GIE_RESET 1'h0
`define IMX_RETIRQ_CYCLES 2'h2
`define IMX_RESET_PULSE_CYCLES 4'h4
`endif

// [imx_ptr_unit.v]
// pointer arithmetic for the indirect move: effective address and update
// assumes purely combinational use by the executing core
`timescale 1ns/1ps
`include "imx_defs.vh"
module imx_ptr_unit
(
    ptr,
    mode,
    use_offset,
    offset,
    eff_addr,
    nxt_ptr
);
    input wire [15:0] ptr;
    input wire [1:0] mode;
    input wire use_offset;
    input wire [5:0] offset;
    output reg [15:0] eff_addr;
    output reg [15:0] nxt_ptr;
    wire [15:0] ptr_inc;
    wire [15:0] ptr_dec;
    wire [15:0] ptr_off;
    // 16-bit adds drop the carry so the pointer wraps
    assign ptr_inc = ptr + 16'h0001;
    assign ptr_dec = ptr - 16'h0001;
    assign ptr_off = ptr + {{10{offset[5]}}, offset};
    always @*
    begin
        eff_addr = ptr;
        nxt_ptr = ptr;
        if (use_offset)
        begin
            eff_addr = ptr_off;
        end
        else
        begin
            case (mode)
                `IMX_MM_PREINC:
                begin
                    eff_addr = ptr_inc;
                    nxt_ptr = ptr_inc;
                end
                `IMX_MM_PREDEC:
                begin
                    eff_addr = ptr_dec;
                    nxt_ptr = ptr_dec;
                end
                `IMX_MM_POSTINC:
                begin
                    nxt_ptr = ptr_inc;
                end
                default:
                begin
                    nxt_ptr = ptr_dec;
                end
            endcase
        end
    end
endmodule

// [imx_exec.v]
// execution unit for indirect move, software reset, return and xor ops
// assumes the decoder pulses op_valid for one cycle, data bus reads are
// combinational and the stack pops on the pulse it is given
`timescale 1ns/1ps
`include "imx_defs.vh"
module imx_exec
(
    core_clk,
    resetn,
    op_valid,
    op_code,
    op_ptr_sel,
    op_mode,
    op_offset,
    op_literal,
    op_faddr,
    op_dest,
    busy,
    w_ff,
    ptr0_ff,
    ptr1_ff,
    zero_flag_ff,
    global_irq_enable_ff,
    reset_instruction_flag_ff,
    dmem_addr,
    dmem_rdata,
    dmem_wdata,
    dmem_we,
    stack_top,
    stack_pop,
    pc_load,
    pc_value,
    sw_reset_req
);
    input wire core_clk;
    input wire resetn;
    input wire op_valid;
    input wire [2:0] op_code;
    input wire op_ptr_sel;
    input wire [1:0] op_mode;
    input wire [5:0] op_offset;
    input wire [7:0] op_literal;
    input wire [6:0] op_faddr;
    input wire op_dest;
    output wire busy;
    output reg [7:0] w_ff;
    output reg [15:0] ptr0_ff;
    output reg [15:0] ptr1_ff;
    output reg zero_flag_ff;
    output reg global_irq_enable_ff;
    output reg reset_instruction_flag_ff;
    output reg [15:0] dmem_addr;
    input wire [7:0] dmem_rdata;
    output reg [7:0] dmem_wdata;
    output reg dmem_we;
    input wire [14:0] stack_top;
    output wire stack_pop;
    output wire pc_load;
    output wire [14:0] pc_value;
    output wire sw_reset_req;

    // ****************************************************************
    // pointer selection and arithmetic
    // ****************************************************************
    wire [15:0] sel_ptr;
    wire [15:0] eff_addr;
    wire [15:0] upd_ptr;
    wire [7:0] xor_lit;
    wire [7:0] xor_file;
    reg [1:0] ret_cnt_ff;
    reg [3:0] rst_cnt_ff;

    assign sel_ptr = op_ptr_sel ? ptr1_ff : ptr0_ff;

    imx_ptr_unit u_ptr
    (
        .ptr(sel_ptr),
        .mode(op_mode),
        .use_offset(op_code == `IMX_OP_MOVE_W_INDIRECT_OP_K),
        .offset(op_offset),
        .eff_addr(eff_addr),
        .nxt_ptr(upd_ptr)
    );

    assign xor_lit = w_ff ^ op_literal;
    assign xor_file = w_ff ^ dmem_rdata;
    assign busy = (ret_cnt_ff != 2'h0) || (rst_cnt_ff != 4'h0);
    assign sw_reset_req = (rst_cnt_ff != 4'h0);

    wire take;
    assign take = op_valid && !busy;

    // ****************************************************************
    // data memory port
    // ****************************************************************
    always @*
    begin
        dmem_addr = {9'h000, op_faddr};
        dmem_wdata = w_ff;
        dmem_we = 1'b0;
        if (take && (op_code == `IMX_OP_MOVE_W_INDIRECT_OP || op_code == `IMX_OP_MOVE_W_INDIRECT_OP_K))
        begin
            dmem_addr = eff_addr;
            dmem_we = 1'b1;
        end
        else if (take && op_code == `IMX_OP_XOR_FILE_OP)
        begin
            dmem_wdata = xor_file;
            dmem_we = op_dest;
        end
    end

    // ****************************************************************
    // architectural state
    // ****************************************************************
    reg [7:0] nxt_w;
    reg [15:0] nxt_ptr0;
    reg [15:0] nxt_ptr1;
    reg nxt_zero_flag;
    reg nxt_global_irq_enable;
    reg nxt_reset_instruction_flag;
    reg [1:0] nxt_ret_cnt;
    reg [3:0] nxt_rst_cnt;
    reg nxt_stack_pop;
    reg nxt_pc_load;
    reg [14:0] nxt_pc_value;
    reg stack_pop_ff;
    reg pc_load_ff;
    reg [14:0] pc_value_ff;

    assign stack_pop = stack_pop_ff;
    assign pc_load = pc_load_ff;
    assign pc_value = pc_value_ff;

    // counters only load when idle, since take needs busy low
    always @*
    begin
        nxt_w = w_ff;
        nxt_ptr0 = ptr0_ff;
        nxt_ptr1 = ptr1_ff;
        nxt_zero_flag = zero_flag_ff;
        nxt_global_irq_enable = global_irq_enable_ff;
        nxt_reset_instruction_flag = reset_instruction_flag_ff;
        nxt_ret_cnt = ret_cnt_ff;
        nxt_rst_cnt = rst_cnt_ff;
        nxt_stack_pop = 1'h0;
        nxt_pc_load = 1'h0;
        nxt_pc_value = pc_value_ff;
        if (ret_cnt_ff != 2'h0)
        begin
            nxt_ret_cnt = ret_cnt_ff - 2'h1;
        end
        if (rst_cnt_ff != 4'h0)
        begin
            nxt_rst_cnt = rst_cnt_ff - 4'h1;
        end
        if (take)
        begin
            case (op_code)
                `IMX_OP_MOVE_W_INDIRECT_OP:
                begin
                    // flags untouched by the pointer update
                    if (op_ptr_sel)
                    begin
                        nxt_ptr1 = upd_ptr;
                    end
                    else
                    begin
                        nxt_ptr0 = upd_ptr;
                    end
                end
                `IMX_OP_RESET:
                begin
                    nxt_reset_instruction_flag = 1'h0;
                    nxt_rst_cnt = `IMX_RESET_PULSE_CYCLES;
                end
                `IMX_OP_RETIRQ:
                begin
                    nxt_stack_pop = 1'h1;
                    nxt_pc_load = 1'h1;
                    nxt_pc_value = stack_top;
                    nxt_global_irq_enable = 1'h1;
                    nxt_ret_cnt = `IMX_RETIRQ_CYCLES - 2'h1;
                end
                `IMX_OP_XOR_LITERAL_OP:
                begin
                    nxt_w = xor_lit;
                    nxt_zero_flag = (xor_lit == 8'h00);
                end
                `IMX_OP_XOR_FILE_OP:
                begin
                    if (!op_dest)
                    begin
                        nxt_w = xor_file;
                    end
                    nxt_zero_flag = (xor_file == 8'h00);
                end
                default:
                begin
                    nxt_w = w_ff;
                end
            endcase
        end
    end

    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            w_ff <= `IMX_W_RESET;
            ptr0_ff <= `IMX_PTR_RESET;
            ptr1_ff <= `IMX_PTR_RESET;
            zero_flag_ff <= `IMX_ZERO_RESET;
            global_irq_enable_ff <= `IMX_GIE_RESET;
            reset_instruction_flag_ff <= `IMX_RI_RESET;
            ret_cnt_ff <= 2'h0;
            rst_cnt_ff <= 4'h0;
            stack_pop_ff <= 1'h0;
            pc_load_ff <= 1'h0;
            pc_value_ff <= 15'h0000;
        end
        else
        begin
            w_ff <= nxt_w;
            ptr0_ff <= nxt_ptr0;
            ptr1_ff <= nxt_ptr1;
            zero_flag_ff <= nxt_zero_flag;
            global_irq_enable_ff <= nxt_global_irq_enable;
            reset_instruction_flag_ff <= nxt_reset_instruction_flag;
            ret_cnt_ff <= nxt_ret_cnt;
            rst_cnt_ff <= nxt_rst_cnt;
            stack_pop_ff <= nxt_stack_pop;
            pc_load_ff <= nxt_pc_load;
            pc_value_ff <= nxt_pc_value;
        end
    end
endmodule

// [imx_exec_assertions.sv]
// checker for the execution unit ports
// assumes one clock domain, bound onto imx_exec
`timescale 1ns/1ps
`include "imx_defs.vh"
module imx_exec_assertions
(
    input wire core_clk,
    input wire resetn,
    input wire op_valid,
    input wire [2:0] op_code,
    input wire [7:0] op_literal,
    input wire busy,
    input wire [7:0] w_ff,
    input wire zero_flag_ff,
    input wire global_irq_enable_ff,
    input wire reset_instruction_flag_ff,
    input wire dmem_we,
    input wire [7:0] dmem_wdata,
    input wire [14:0] stack_top,
    input wire stack_pop,
    input wire pc_load,
    input wire [14:0] pc_value,
    input wire sw_reset_req
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    wire take = op_valid && !busy;
    wire mv = take && (op_code == `IMX_OP_MOVE_W_INDIRECT_OP || op_code == `IMX_OP_MOVE_W_INDIRECT_OP_K);
    sequence s_ret_busy;
        busy ##1 !busy;
    endsequence
    sequence s_req_pulse;
        sw_reset_req [*4] ##1 !sw_reset_req;
    endsequence
    a_xor_literal: assert property (take && op_code == `IMX_OP_XOR_LITERAL_OP |=>
        w_ff == ($past(w_ff) ^ $past(op_literal))) else $error("xor literal wrong");
    a_zero_flag: assert property (take && op_code == `IMX_OP_XOR_LITERAL_OP |=>
        zero_flag_ff == (w_ff == 8'h00)) else $error("zero flag wrong");
    a_move_write: assert property (mv |-> dmem_we && dmem_wdata == w_ff)
        else $error("indirect write missing");
    a_move_status: assert property (mv |=> $stable(zero_flag_ff))
        else $error("status changed by move");
    a_return_load: assert property (take && op_code == `IMX_OP_RETIRQ |=>
        stack_pop && pc_load && pc_value == $past(stack_top)) else $error("return load wrong");
    a_return_irq: assert property (take && op_code == `IMX_OP_RETIRQ |=>
        global_irq_enable_ff ##0 s_ret_busy) else $error("return enable or length wrong");
    a_return_status: assert property (take && op_code == `IMX_OP_RETIRQ |=>
        $stable(zero_flag_ff)) else $error("status changed by return");
    a_reset_pulse: assert property (take && op_code == `IMX_OP_RESET |=>
        !reset_instruction_flag_ff ##0 s_req_pulse) else $error("software reset wrong");
endmodule
bind imx_exec imx_exec_assertions u_chk
(
    .core_clk, .resetn, .op_valid, .op_code, .op_literal, .busy, .w_ff, .zero_flag_ff,
    .global_irq_enable_ff, .reset_instruction_flag_ff, .dmem_we, .dmem_wdata,
    .stack_top, .stack_pop, .pc_load, .pc_value, .sw_reset_req
);

// [imx_exec_tb_top.sv]
// self-checking bench for the execution unit
// assumes imx_exec and its checker are compiled alongside
`timescale 1ns/1ps
`include "imx_defs.vh"
module imx_exec_tb_top;
    reg core_clk = 1'b0;
    reg resetn = 1'b0;
    reg op_valid = 1'b0;
    reg [2:0] op_code = 3'h0;
    reg op_ptr_sel = 1'b0;
    reg [1:0] op_mode = 2'h0;
    reg [5:0] op_offset = 6'h00;
    reg [7:0] op_literal = 8'h00;
    reg [6:0] op_faddr = 7'h00;
    reg op_dest = 1'b0;
    reg [14:0] stack_top = 15'h1234;
    reg [7:0] mem [0:255];
    reg [15:0] seen_addr;
    wire busy, zero_flag_ff, global_irq_enable_ff, reset_instruction_flag_ff;
    wire dmem_we, stack_pop, pc_load, sw_reset_req;
    wire [7:0] w_ff, dmem_wdata;
    wire [15:0] ptr0_ff, ptr1_ff, dmem_addr;
    wire [14:0] pc_value;
    wire [7:0] dmem_rdata = mem[dmem_addr[7:0]];
    integer errors = 0, total_checks = 0, cycles = 0, i;
    imx_exec DUT (.core_clk, .resetn, .op_valid, .op_code, .op_ptr_sel, .op_mode, .op_offset,
        .op_literal, .op_faddr, .op_dest, .busy, .w_ff, .ptr0_ff, .ptr1_ff, .zero_flag_ff,
        .global_irq_enable_ff, .reset_instruction_flag_ff, .dmem_addr, .dmem_rdata,
        .dmem_wdata, .dmem_we, .stack_top, .stack_pop, .pc_load, .pc_value, .sw_reset_req);
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        if (dmem_we)
            mem[dmem_addr[7:0]] <= dmem_wdata;
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            errors = errors + 1;
            conclude;
        end
    end
    task chk(input string what, input [15:0] exp, input [15:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp)
            begin
                errors = errors + 1;
                $display("Error %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // ****************
    // one op, taken at the second edge; returns just after it
    // ****************
    task issue(input [2:0] code);
        begin
            @(posedge core_clk);
            #1 op_code = code;
            op_valid = 1'b1;
            #2 seen_addr = dmem_addr;
            @(posedge core_clk);
            #1 op_valid = 1'b0;
        end
    endtask
    task mv(input [1:0] mode, input [15:0] ea, input [15:0] np);
        begin
            op_mode = mode;
            issue(`IMX_OP_MOVE_W_INDIRECT_OP);
            chk("addr", ea, seen_addr);
            chk("ptr", np, ptr0_ff);
            chk("data", 16'h0000, mem[ea[7:0]]);
            chk("zero", 16'h0001, zero_flag_ff);
        end
    endtask
    task t_xor;
        begin
            op_literal = 8'hA5;
            issue(`IMX_OP_XOR_LITERAL_OP);
            chk("w", 16'h00A5, w_ff);
            chk("zero", 16'h0000, zero_flag_ff);
            issue(`IMX_OP_XOR_LITERAL_OP);
            chk("w", 16'h0000, w_ff);
            chk("zero", 16'h0001, zero_flag_ff);
            $display("xor literal test done");
        end
    endtask
    task t_move;
        begin
            mv(2'h0, 16'h0001, 16'h0001);
            mv(2'h1, 16'h0000, 16'h0000);
            mv(2'h3, 16'h0000, 16'hFFFF);
            mv(2'h2, 16'hFFFF, 16'h0000);
            op_ptr_sel = 1'b1;
            op_offset = 6'h3F;
            issue(`IMX_OP_MOVE_W_INDIRECT_OP_K);
            chk("addr", 16'hFFFF, seen_addr);
            chk("ptr1", 16'h0000, ptr1_ff);
            $display("indirect move test done");
        end
    endtask
    task t_xor_file_op;
        begin
            op_literal = 8'h5A;
            issue(`IMX_OP_XOR_LITERAL_OP);
            op_faddr = 7'h7F;
            issue(`IMX_OP_XOR_FILE_OP);
            chk("w", 16'h0066, w_ff);
            chk("faddr", 16'h007F, seen_addr);
            op_dest = 1'b1;
            issue(`IMX_OP_XOR_FILE_OP);
            chk("file", 16'h005A, mem[127]);
            chk("w", 16'h0066, w_ff);
            op_literal = 8'h3C;
            issue(`IMX_OP_XOR_LITERAL_OP);
            op_dest = 1'b0;
            issue(`IMX_OP_XOR_FILE_OP);
            chk("w", 16'h0000, w_ff);
            chk("zero", 16'h0001, zero_flag_ff);
            $display("xor file test done");
        end
    endtask
    task t_ret;
        begin
            @(posedge core_clk);
            #1 op_code = `IMX_OP_RETIRQ;
            op_valid = 1'b1;
            @(posedge core_clk);
            // valid held into the busy cycle must be refused
            #1 op_code = `IMX_OP_XOR_LITERAL_OP;
            op_literal = 8'hFF;
            chk("pop", 16'h0001, stack_pop);
            chk("load", 16'h0001, pc_load);
            chk("pc", 16'h1234, pc_value);
            chk("irq", 16'h0001, global_irq_enable_ff);
            chk("busy", 16'h0001, busy);
            chk("zero", 16'h0001, zero_flag_ff);
            @(posedge core_clk);
            #1 op_valid = 1'b0;
            chk("w", 16'h0000, w_ff);
            chk("busy", 16'h0000, busy);
            chk("pop", 16'h0000, stack_pop);
            $display("return test done");
        end
    endtask
    task t_reset;
        begin
            issue(`IMX_OP_RESET);
            chk("flag", 16'h0000, reset_instruction_flag_ff);
            chk("zero", 16'h0001, zero_flag_ff);
            i = 0;
            repeat (6)
            begin
                if (sw_reset_req === 1'b1)
                    i = i + 1;
                @(posedge core_clk);
                #1;
            end
            chk("req", 16'h0004, i[15:0]);
            resetn = 1'b0;
            @(posedge core_clk);
            #1 resetn = 1'b1;
            chk("flag", 16'h0001, reset_instruction_flag_ff);
            chk("w", 16'h0000, w_ff);
            $display("software reset test done");
        end
    endtask
    task conclude;
        begin
            $display("checks %0d errors %0d", total_checks, errors);
            if (errors == 0 && total_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial
    begin
        mem[127] = 8'h3C;
        repeat (5) @(posedge core_clk);
        #1 resetn = 1'b1;
        t_xor;
        t_move;
        t_xor_file_op;
        t_ret;
        t_reset;
        conclude;
    end
endmodule
